// file: hw/srg_pkg.sv
// Purpose: Shared constants for the system reset generator
// Assumes: Always-on clock of 125 MHz
// Notes: Times are in ns; cycle counts derive from them, least times rounded up
package srg_pkg;
  localparam int CLK_FREQ_MHZ = 125;
  // Pin filter settle time, analog init time, least reset pulse width
  localparam int DEB_TIME_NS = 1000;
  localparam int ANA_INIT_NS = 4000;
  localparam int RST_HOLD_NS = 800;
  localparam int DEB_CYCLES = (DEB_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int ANA_INIT_CYCLES = (ANA_INIT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int RST_HOLD_CYCLES = (RST_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
  localparam int NUM_RAILS = 4;
  // Source positions in the request and cause vectors
  localparam int SRC_PIN = 0;
  localparam int SRC_BRN_LO = 1;
  localparam int SRC_BRN_HI = 2;
  localparam int SRC_RAIL0 = 3;
  localparam int SRC_CPU = 7;
  localparam int SRC_SWP = 8;
  localparam int SRC_WDT = 9;
  localparam int SRC_POR = 10;
  localparam int NUM_SRC = 11;
  localparam int NUM_ASYNC = 9;
  // Software trigger needs no synchroniser, so watchdog sits one bit lower there
  localparam int SYNC_WDT = NUM_ASYNC - 1;
  localparam int NUM_STAT = 5;
  localparam logic [NUM_SRC-1:0] CAUSE_RESET = 11'h400;
  localparam logic [NUM_STAT-1:0] STAT_RESET = 5'h00;
  typedef enum logic [1:0] {
    ST_POR_WAIT,
    ST_ANA_INIT,
    ST_ASSERT,
    ST_RUN
  } srg_state_t;
endpackage : srg_pkg

// file: hw/srg_deb_if.sv
// Purpose: Carries the pin level into and out of the debounce filter
// Assumes: raw is already synchronised to i_clk
// Notes: level is active high, meaning the pin is held low
`timescale 1ns/100ps
interface srg_deb_if;
  logic raw;
  logic level;
  modport filt (input raw, output level);
  modport user (output raw, input level);
endinterface : srg_deb_if

// file: hw/srg_debounce.sv
// Purpose: Debounce filter for the external reset pin
// Assumes: Input synchronised; one clock domain
// Notes: Level follows raw only after raw holds steady for CYCLES clocks
`timescale 1ns/100ps
module srg_debounce #(
  parameter int CYCLES = srg_pkg::DEB_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  srg_deb_if.filt deb
);
  import srg_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic level_q;

  assign deb.level = level_q;

  // Any bounce restarts the count, so glitches never reach the level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (deb.raw == level_q) begin
      cnt_q <= '0; // RL4
    end else if (cnt_q == CNT_W'(CYCLES - 1)) begin
      cnt_q <= '0;
      level_q <= deb.raw; // RL4
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  logic [CNT_W-1:0] stable_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stable_q <= '0;
    end else if (deb.raw != $past(deb.raw)) begin
      stable_q <= '0;
    end else if (stable_q != {CNT_W{1'b1}}) begin
      stable_q <= stable_q + CNT_W'(1);
    end
  end

  deb_stable_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL4
    $changed(level_q) |-> $past(deb.raw) == level_q && $past(stable_q) >= CNT_W'(CYCLES - 2))
    else $error("Pin level changed before input settled");
endmodule : srg_debounce

// file: hw/srg_reset_gen.sv
// Purpose: System reset generator for the always-on domain
// Assumes: i_nrst is the block's own power-on reset; i_clk is always running
// Notes: Cause and status survive system reset; power-on sets cause to its power-on bit and clears status, status also on i_status_clear
//
// Functional notes
// [RL1] Any unmasked reset source drives the active-low system reset low.
// [RL2] System reset reinitialises everything except brownout-retained logic.
// [RL3] Cause of the latest reset stays readable after release.
// [RL4] Reset pin is debounced and cannot be masked.
// [RL5] Brownout turns on the pin pull-down, driving the pin low.
// [RL6] After power good, analog init runs before system reset releases.
// [RL7] Supply falling below power-on threshold reasserts reset at once.
// [RL8] Power-on reset has no mask.
// [RL9] Low-threshold brownout always resets, no enable.
// [RL10] High brownout resets only if enabled; interrupts only if enabled.
// [RL11] Software avoids high brownout reset enable below 2.1V supply.
// [RL12] Four rail monitors each give a separately maskable reset.
// [RL13] Enabled high or rail brownout resets and pulls the pin low.
// [RL14] High and rail brownout resets each set a sticky status bit.
// [RL15] Clock and timer registers keep state during brownout until power-down.
// [RL16] Processor software reset request always resets.
// [RL17] Software trigger gives the same reset as the processor request.
// [RL18] Watchdog reset occurs only when its enable is set.
// [RL19] Sources captured asynchronously, reset released on a clock edge.
`timescale 1ns/100ps
module srg_reset_gen #(
  parameter int DEB_CYC = srg_pkg::DEB_CYCLES,
  parameter int ANA_CYC = srg_pkg::ANA_INIT_CYCLES,
  parameter int HOLD_CYC = srg_pkg::RST_HOLD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_power_on_reset_n,
  input wire logic i_ext_reset_pin_n,
  input wire logic i_brownout_low_threshold,
  input wire logic i_brownout_high_threshold,
  input wire logic [srg_pkg::NUM_RAILS-1:0] i_rail_brownout,
  input wire logic i_cpu_sw_reset_request_n,
  input wire logic i_software_power_on_trigger,
  input wire logic i_watchdog_expired,
  input wire logic i_brownout_high_reset_enable,
  input wire logic i_brownout_high_int_enable,
  input wire logic [srg_pkg::NUM_RAILS-1:0] i_rail_reset_enable,
  input wire logic i_watchdog_reset_enable,
  input wire logic i_status_clear,
  output logic o_system_reset_n,
  output logic o_retention_reset_n,
  output logic o_analog_init,
  output logic o_ext_reset_pin_n_out,
  output logic o_ext_reset_pin_n_oe,
  output logic o_brownout_high_irq,
  output logic [srg_pkg::NUM_SRC-1:0] o_reset_cause,
  output logic [srg_pkg::NUM_STAT-1:0] o_reset_interrupt_status
);
  import srg_pkg::*;

  // Power-on detector and block reset share one asynchronous path
  logic por_rst_n;
  assign por_rst_n = i_nrst & i_power_on_reset_n; // RL7 RL8

  // Reset synchroniser: drops at once, releases on a clock edge
  logic por_s1_q;
  logic por_ok_q;
  always_ff @(posedge i_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      por_s1_q <= 1'b0; // RL19
      por_ok_q <= 1'b0;
    end else begin
      por_s1_q <= 1'b1;
      por_ok_q <= por_s1_q; // RL19
    end
  end

  // Level sources from other domains, active high
  logic [NUM_ASYNC-1:0] async_in;
  logic [NUM_ASYNC-1:0] sync1_q;
  logic [NUM_ASYNC-1:0] sync_q;
  assign async_in = {i_watchdog_expired, ~i_cpu_sw_reset_request_n, i_rail_brownout,
                     i_brownout_high_threshold, i_brownout_low_threshold, ~i_ext_reset_pin_n};

  genvar g;
  generate
    for (g = 0; g < NUM_ASYNC; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          sync1_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= async_in[g]; // RL19
          sync_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  srg_deb_if deb_if ();
  assign deb_if.raw = sync_q[SRC_PIN];

  srg_debounce #(
    .CYCLES(DEB_CYC)
  ) u_debounce (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .deb(deb_if)
  );

  // Gated request vector; power-on is handled on the asynchronous path
  logic [NUM_SRC-1:0] req;
  logic [NUM_RAILS-1:0] rail_s;
  logic any_req;
  logic brownout_any;
  assign rail_s = sync_q[SRC_RAIL0 +: NUM_RAILS];
  always_comb begin
    req = '0;
    req[SRC_PIN] = deb_if.level; // RL4
    req[SRC_BRN_LO] = sync_q[SRC_BRN_LO]; // RL9
    req[SRC_BRN_HI] = sync_q[SRC_BRN_HI] & i_brownout_high_reset_enable; // RL10 RL11
    req[SRC_RAIL0 +: NUM_RAILS] = rail_s & i_rail_reset_enable; // RL12
    req[SRC_CPU] = sync_q[SRC_CPU]; // RL16
    req[SRC_SWP] = i_software_power_on_trigger; // RL17
    req[SRC_WDT] = sync_q[SYNC_WDT] & i_watchdog_reset_enable; // RL18
  end
  assign any_req = |req; // RL1
  assign brownout_any = sync_q[SRC_BRN_LO] | req[SRC_BRN_HI] | (|req[SRC_RAIL0 +: NUM_RAILS]);

  // Sequencer
  srg_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic sys_n_q;
  logic ana_q;
  always_ff @(posedge i_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      state_q <= ST_POR_WAIT;
      cnt_q <= '0;
      sys_n_q <= 1'b0; // RL7
      ana_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_POR_WAIT: begin
          if (por_ok_q) begin
            state_q <= ST_ANA_INIT; // RL6
            ana_q <= 1'b1;
            cnt_q <= '0;
          end
        end
        ST_ANA_INIT: begin
          if (cnt_q == CNT_W'(ANA_CYC - 1)) begin
            ana_q <= 1'b0;
            cnt_q <= '0;
            state_q <= any_req ? ST_ASSERT : ST_RUN; // RL6
            sys_n_q <= !any_req;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        ST_ASSERT: begin
          // Hold until every unmasked source has gone quiet for the full width
          if (any_req) begin
            cnt_q <= '0; // RL2
          end else if (cnt_q == CNT_W'(HOLD_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= ST_RUN;
            sys_n_q <= 1'b1; // RL19
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        ST_RUN: begin
          if (any_req) begin
            state_q <= ST_ASSERT;
            sys_n_q <= 1'b0; // RL1
            cnt_q <= '0;
          end
        end
      endcase
    end
  end

  // Cause of the most recent reset; reset value marks power-on
  logic [NUM_SRC-1:0] cause_q;
  always_ff @(posedge i_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      cause_q <= CAUSE_RESET; // RL3
    end else if (state_q == ST_RUN && any_req) begin
      cause_q <= req; // RL3
    end
  end

  // Sticky brownout status; a new event wins over a clear
  logic [NUM_STAT-1:0] stat_q;
  logic [NUM_STAT-1:0] stat_set;
  assign stat_set = {req[SRC_RAIL0 +: NUM_RAILS], req[SRC_BRN_HI]};
  always_ff @(posedge i_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      stat_q <= STAT_RESET;
    end else begin
      stat_q <= (i_status_clear ? '0 : stat_q) | stat_set; // RL14
    end
  end

  // Pin pull-down while low brownout or an enabled high or rail brownout is present
  logic pd_q;
  logic irq_q;
  always_ff @(posedge i_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      pd_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pd_q <= brownout_any; // RL5 RL13
      irq_q <= sync_q[SRC_BRN_HI] & i_brownout_high_int_enable; // RL10
    end
  end

  // Retention domain only sees power-on, not brownout or other sources
  logic ret_n_q;
  always_ff @(posedge i_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      ret_n_q <= 1'b0;
    end else begin
      ret_n_q <= por_ok_q; // RL15
    end
  end

  assign o_system_reset_n = sys_n_q;
  assign o_retention_reset_n = ret_n_q;
  assign o_analog_init = ana_q;
  assign o_ext_reset_pin_n_out = 1'b0;
  assign o_ext_reset_pin_n_oe = pd_q;
  assign o_brownout_high_irq = irq_q;
  assign o_reset_cause = cause_q;
  assign o_reset_interrupt_status = stat_q;

  // Helper: analog init completed since last power-on
  logic init_done_q;
  always_ff @(posedge i_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      init_done_q <= 1'b0;
    end else if (state_q == ST_ANA_INIT && cnt_q == CNT_W'(ANA_CYC - 1)) begin
      init_done_q <= 1'b1;
    end
  end

  req_asserts_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL1
    state_q == ST_RUN && any_req |=> !sys_n_q)
    else $error("Request did not assert system reset");

  no_req_run_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL10
    state_q == ST_RUN && req == '0 |=> sys_n_q && state_q == ST_RUN)
    else $error("Reset asserted with no unmasked source");

  por_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL7
    !por_ok_q |-> !sys_n_q && !ret_n_q)
    else $error("System reset released without power good");

  ana_first_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL6
    $rose(sys_n_q) |-> init_done_q && !ana_q)
    else $error("Reset released before analog init");

  hold_width_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL2
    $fell(sys_n_q) |-> !sys_n_q [*8])
    else $error("System reset pulse too short");

  cause_rec_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL3
    state_q == ST_RUN && any_req |=> cause_q == $past(req) && state_q == ST_ASSERT)
    else $error("Reset cause not recorded");

  sw_same_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL17
    state_q == ST_RUN && i_software_power_on_trigger |=> !sys_n_q ##1 !sys_n_q)
    else $error("Software trigger did not reset");

  pulldown_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL5
    sync_q[SRC_BRN_LO] |=> pd_q)
    else $error("Brownout did not pull pin low");

  bhi_stat_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL14
    req[SRC_BRN_HI] |=> stat_q[0])
    else $error("High brownout status not set");

  wdt_mask_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL18
    state_q == ST_RUN && sync_q[SYNC_WDT] && !i_watchdog_reset_enable
      && (req & ~(11'h001 << SRC_WDT)) == '0 |=> sys_n_q)
    else $error("Masked watchdog caused reset");

  retain_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL15
    ##1 por_ok_q && $past(por_ok_q) |-> ret_n_q)
    else $error("Retention domain reset by brownout");

  bro_lo_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL9
    state_q == ST_RUN && sync_q[SRC_BRN_LO] |=> !sys_n_q)
    else $error("Low brownout did not reset");

  por_cause_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL8
    $rose(por_ok_q) |-> cause_q == CAUSE_RESET)
    else $error("Power-on cause not recorded");

  cpu_req_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL16
    state_q == ST_RUN && sync_q[SRC_CPU] |=> !sys_n_q)
    else $error("Processor request did not reset");

  rail_req_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL12
    state_q == ST_RUN && (rail_s & i_rail_reset_enable) != '0 |=> !sys_n_q)
    else $error("Enabled rail brownout did not reset");

  irq_gate_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL10
    irq_q |-> $past(sync_q[SRC_BRN_HI] && i_brownout_high_int_enable))
    else $error("Interrupt without enabled high brownout");

  stat_set_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL14
    stat_set != '0 |=> (stat_q & $past(stat_set)) == $past(stat_set))
    else $error("Status set lost");

  stat_clr_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL14
    i_status_clear && stat_set == '0 |=> stat_q == '0)
    else $error("Status not cleared");

  pd_rail_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL13
    req[SRC_BRN_HI] || (|req[SRC_RAIL0 +: NUM_RAILS]) |=> pd_q)
    else $error("Enabled brownout did not pull pin low");

  pd_off_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL5
    !brownout_any |=> !pd_q)
    else $error("Pin pulled low without brownout");

  ana_len_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL6
    $rose(ana_q) |-> ana_q [*4])
    else $error("Analog init too short");

  pin_unmask_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL4
    state_q == ST_RUN && deb_if.level |=> !sys_n_q)
    else $error("Debounced pin did not reset");

  ret_sys_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL2
    !ret_n_q |-> !sys_n_q)
    else $error("System released during retention reset");

  run_rel_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL1
    state_q == ST_RUN |-> sys_n_q)
    else $error("System reset low while running");

  rel_edge_a: assert property (@(posedge i_clk) disable iff (!por_rst_n) // RL19
    $rose(sys_n_q) |-> state_q == ST_RUN && $past(state_q) != ST_RUN)
    else $error("Release not tied to run entry");
endmodule : srg_reset_gen

// file: test/srg_pin_model.sv
// Purpose: Reset pin pad: pull-up, push-button and device pull-down
// Assumes: Button press is active high from the bench
// Notes: Resolves the wire level from every party
`timescale 1ns/100ps
module srg_pin_model (
  input wire logic i_press,
  input wire logic i_pin_n_out,
  input wire logic i_pin_n_oe,
  output logic o_pin_n
);
  // Pull-up wins only when nobody pulls low
  assign o_pin_n = (i_pin_n_oe && !i_pin_n_out) ? 1'b0 : !i_press;
endmodule : srg_pin_model

// file: test/system_reset_generator_tb_top.sv
// Purpose: Self-checking bench for the system reset generator
// Assumes: Short counts of 4, 4 and 10 cycles
// Notes: Sources other than power-on and software trigger are driven through one vector indexed like the cause bits
`timescale 1ns/100ps
module system_reset_generator_tb_top;
  import srg_pkg::*;
  localparam int HOLD = 10;
  logic i_clk, i_nrst, por_n, sw_trig, bhi_en, bhi_ie, wdt_en, st_clr, pin_n;
  logic sys_n, ret_n, ana, pin_out, pin_oe, irq;
  logic [3:0] rail_en;
  logic [NUM_SRC-1:0] src, cause;
  logic [NUM_STAT-1:0] stat;
  int n_errors, comparisons;
  srg_pin_model pin (.i_press(src[SRC_PIN]), .i_pin_n_out(pin_out), .i_pin_n_oe(pin_oe),
    .o_pin_n(pin_n));
  srg_reset_gen #(.DEB_CYC(4), .ANA_CYC(4), .HOLD_CYC(HOLD)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_power_on_reset_n(por_n), .i_ext_reset_pin_n(pin_n),
    .i_brownout_low_threshold(src[SRC_BRN_LO]), .i_brownout_high_threshold(src[SRC_BRN_HI]),
    .i_rail_brownout(src[SRC_RAIL0+:4]), .i_cpu_sw_reset_request_n(!src[SRC_CPU]),
    .i_software_power_on_trigger(sw_trig), .i_watchdog_expired(src[SRC_WDT]),
    .i_brownout_high_reset_enable(bhi_en), .i_brownout_high_int_enable(bhi_ie),
    .i_rail_reset_enable(rail_en), .i_watchdog_reset_enable(wdt_en), .i_status_clear(st_clr),
    .o_system_reset_n(sys_n), .o_retention_reset_n(ret_n), .o_analog_init(ana),
    .o_ext_reset_pin_n_out(pin_out), .o_ext_reset_pin_n_oe(pin_oe),
    .o_brownout_high_irq(irq), .o_reset_cause(cause), .o_reset_interrupt_status(stat));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // Bounded wait for release; notes whether analog init was seen on the way
  task automatic wait_rel(output bit saw_init);
    saw_init = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge i_clk);
      if (ana === 1'b1) saw_init = 1;
      if (sys_n === 1'b1) return;
    end
    n_errors++;
    $display("Error at %0t: seen %0h expected %0h", $time, sys_n, 1'b1);
    end_sim();
  endtask : wait_rel
  task automatic fire(input int idx, input logic rst, input logic brown);
    bit s;
    logic [NUM_SRC-1:0] exp_c;
    exp_c = rst ? (NUM_SRC'(1) << idx) : cause;
    @(posedge i_clk);
    src[idx] <= 1'b1;
    repeat (12) @(negedge i_clk);
    check(16'(sys_n), 16'(!rst));
    check(16'(pin_oe), 16'(brown));
    check(16'(ret_n), 16'h1);
    check(16'(pin_n), 16'(!(brown || idx == SRC_PIN)));
    @(posedge i_clk);
    src[idx] <= 1'b0;
    // Request gone, reset must still stretch
    repeat (HOLD - 2) @(negedge i_clk);
    check(16'(sys_n), 16'(!rst));
    wait_rel(s);
    check(16'(cause), 16'(exp_c));
  endtask : fire
  task automatic t_power_on();
    bit s;
    @(posedge i_clk);
    i_nrst <= 1'b1;
    wait_rel(s);
    check(16'(s), 16'h1);
    check(16'(cause), 16'(CAUSE_RESET));
    check(16'(stat), 16'(STAT_RESET));
    $display("Test power_on done");
  endtask : t_power_on
  task automatic t_sources();
    @(posedge i_clk);
    bhi_en <= 1'b1;
    rail_en <= 4'hF;
    wdt_en <= 1'b1;
    for (int i = 0; i < SRC_POR; i++) begin
      if (i != SRC_SWP) begin
        fire(i, 1'b1, i >= SRC_BRN_LO && i < SRC_CPU);
        if (i >= SRC_BRN_HI && i < SRC_CPU) check(16'(stat[i-SRC_BRN_HI]), 16'h1);
      end
    end
    @(posedge i_clk);
    st_clr <= 1'b1;
    @(posedge i_clk);
    st_clr <= 1'b0;
    @(negedge i_clk);
    check(16'(stat), 16'h0);
    $display("Test sources done");
  endtask : t_sources
  task automatic t_masked();
    @(posedge i_clk);
    bhi_en <= 1'b0;
    rail_en <= 4'h0;
    wdt_en <= 1'b0;
    bhi_ie <= 1'b1;
    for (int i = SRC_BRN_HI; i < SRC_CPU; i++) fire(i, 1'b0, 1'b0);
    fire(SRC_WDT, 1'b0, 1'b0);
    check(16'(stat), 16'h0);
    @(posedge i_clk);
    src[SRC_BRN_HI] <= 1'b1;
    repeat (5) @(negedge i_clk);
    check(16'(irq), 16'h1);
    @(posedge i_clk);
    src[SRC_BRN_HI] <= 1'b0;
    bhi_ie <= 1'b0;
    $display("Test masked done");
  endtask : t_masked
  task automatic t_bounce_and_sw();
    bit s;
    @(posedge i_clk);
    src[SRC_PIN] <= 1'b1;
    repeat (2) @(posedge i_clk);
    src[SRC_PIN] <= 1'b0;
    repeat (10) @(negedge i_clk);
    check(16'(sys_n), 16'h1);
    @(posedge i_clk);
    sw_trig <= 1'b1;
    @(posedge i_clk);
    sw_trig <= 1'b0;
    @(negedge i_clk);
    check(16'(sys_n), 16'h0);
    wait_rel(s);
    check(16'(cause), 16'(NUM_SRC'(1) << SRC_SWP));
    $display("Test bounce_and_sw done");
  endtask : t_bounce_and_sw
  task automatic t_por_drop();
    bit s;
    @(posedge i_clk);
    por_n <= 1'b0;
    #1;
    // Must fall before any further clock edge
    check(16'(sys_n), 16'h0);
    check(16'(ret_n), 16'h0);
    check(16'(cause), 16'(CAUSE_RESET));
    @(posedge i_clk);
    por_n <= 1'b1;
    wait_rel(s);
    check(16'(s), 16'h1);
    $display("Test por_drop done");
  endtask : t_por_drop
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    n_errors = 0;
    comparisons = 0;
    {i_nrst, sw_trig, bhi_en, bhi_ie, wdt_en, st_clr} = '0;
    por_n = 1'b1;
    rail_en = 4'h0;
    src = '0;
    repeat (8) @(posedge i_clk);
    t_power_on();
    t_sources();
    t_masked();
    t_bounce_and_sw();
    t_por_drop();
    end_sim();
  end
endmodule : system_reset_generator_tb_top
